// ==== serial_clock_pkg.sv ====
// constants and carrier types for the serial engine clock command block
package serial_clock_pkg;
   localparam logic [7:0] OP_SET_DIVISOR = 8'h86;
   localparam logic [7:0] OP_DIV5_OFF = 8'h8a;
   localparam logic [7:0] OP_DIV5_ON = 8'h8b;
   localparam logic [7:0] OP_THREE_ON = 8'h8c;
   localparam logic [7:0] OP_THREE_OFF = 8'h8d;
   localparam logic [7:0] OP_CLK_BITS = 8'h8e;
   localparam logic [7:0] OP_CLK_BYTES = 8'h8f;
   localparam logic [7:0] OP_CLK_UNTIL_HI = 8'h94;
   localparam logic [7:0] OP_CLK_UNTIL_LO = 8'h95;
   localparam logic [7:0] OP_ADAPT_ON = 8'h96;
   localparam logic [7:0] OP_ADAPT_OFF = 8'h97;
   localparam logic [7:0] OP_BYTES_OR_HI = 8'h9c;
   localparam logic [7:0] OP_BYTES_OR_LO = 8'h9d;
   localparam logic [7:0] OP_DRIVE_ZERO = 8'h9e;
   // front stage divides the internal clock by five: ticks 0..4
   localparam logic [2:0] PRESCALE_LAST = 3'h4;
   localparam logic RST_DIV5 = 1'b1;
   localparam logic RST_THREE_PHASE = 1'b0;
   localparam logic RST_ADAPTIVE = 1'b0;
   localparam logic [15:0] RST_DIVISOR = 16'h0000;
   localparam logic [15:0] RST_DRIVE_ZERO_MASK = 16'h0000;
   localparam logic [1:0] PH_SETUP = 2'h0;
   localparam logic [1:0] PH_PULSE = 2'h1;
   localparam logic [1:0] PH_HOLD = 2'h2;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_ARG = 3'b010,
      ST_RUN = 3'b100
   } fsm_t;

   typedef struct packed
   {
      logic busy;
      logic div5;
      logic three_phase;
      logic adaptive;
      logic [15:0] divisor;
      logic [15:0] drive_zero_mask;
   } status_t;

   typedef struct packed
   {
      logic [15:0] data;
      logic [15:0] dir;
   } pin_cfg_t;

   typedef struct packed
   {
      logic [15:0] level;
      logic [15:0] oe_n;
   } pin_drive_t;
endpackage

// ==== serial_engine_clock_commands.sv ====
// clock generation command block of a byte-driven synchronous serial engine
`timescale 1ns/10ps
module serial_engine_clock_commands
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_clk_en,
   input wire logic i_ctrl_enable,
   input wire logic i_cmd_valid,
   input wire logic [7:0] i_cmd_byte,
   output logic o_cmd_ready,
   input wire logic i_wait_input_line,
   input wire logic i_return_clock_input,
   input wire logic i_clk_idle_level,
   input wire serial_clock_pkg::pin_cfg_t i_pin_cfg,
   output logic o_sclk,
   output logic o_data_out,
   output serial_clock_pkg::pin_drive_t o_pin_drive,
   output serial_clock_pkg::status_t o_status
);
   import serial_clock_pkg::*;

   typedef struct packed
   {
      fsm_t fsm;
      logic [7:0] cmd;
      logic argn;
      logic [7:0] low_byte;
      logic [19:0] pulses;
      logic [1:0] phase;
      logic [2:0] pre;
      logic [15:0] hc;
      logic idle;
      logic sclk;
      logic data_out;
      logic ready;
      logic busy;
      logic div5;
      logic three;
      logic adapt;
      logic [15:0] divisor;
      logic [15:0] mask;
      pin_drive_t pins;
      logic wait_s1;
      logic wait_s2;
      logic ret_s1;
      logic ret_s2;
   } state_t;

   localparam state_t STATE_RST = '{
      fsm: ST_IDLE, cmd: 8'h00, argn: 1'b0, low_byte: 8'h00, pulses: 20'h00000,
      phase: PH_SETUP, pre: 3'h0, hc: 16'h0000, idle: 1'b0, sclk: 1'b0,
      data_out: 1'b0, ready: 1'b1, busy: 1'b0, div5: RST_DIV5, three: RST_THREE_PHASE,
      adapt: RST_ADAPTIVE, divisor: RST_DIVISOR, mask: RST_DRIVE_ZERO_MASK,
      pins: '{level: 16'hffff, oe_n: 16'hffff}, wait_s1: 1'b0, wait_s2: 1'b0,
      ret_s1: 1'b0, ret_s2: 1'b0};

   state_t state_r;
   state_t state_nxt;
   pin_drive_t pin_nxt;

   // per pin drive: masked output pins pull low on zero and float on one
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++)
      begin : g_pin
         always_comb
         begin
            pin_nxt.level[gi] = i_pin_cfg.data[gi];
            pin_nxt.oe_n[gi] = !i_pin_cfg.dir[gi] ||
               (state_r.mask[gi] && i_pin_cfg.data[gi]);
         end
      end
   endgenerate

   always_comb
   begin
      logic take;
      logic tick;
      logic adv;
      logic counted;
      logic wait_hit;
      logic [15:0] len;
      logic [16:0] len_p1;
      state_nxt = state_r;
      take = i_cmd_valid && state_r.ready;
      len = {i_cmd_byte, state_r.low_byte};
      len_p1 = {1'b0, len} + 17'h00001;
      counted = 1'b0;
      wait_hit = 1'b0;
      state_nxt.wait_s1 = i_wait_input_line;
      state_nxt.wait_s2 = state_r.wait_s1;
      state_nxt.ret_s1 = i_return_clock_input;
      state_nxt.ret_s2 = state_r.ret_s1;
      state_nxt.pins = pin_nxt;
      // master tick: every cycle, or every fifth with the front stage in
      tick = !state_r.div5 || (state_r.pre == PRESCALE_LAST);
      state_nxt.pre = (state_r.div5 && state_r.pre != PRESCALE_LAST) ?
         state_r.pre + 3'h1 : 3'h0;
      // hold the next edge until the returned clock follows
      adv = tick && !(state_r.adapt && state_r.ret_s2 != state_r.sclk);
      if (!i_ctrl_enable)
      begin
         state_nxt.fsm = ST_IDLE;
         state_nxt.argn = 1'b0;
         state_nxt.sclk = i_clk_idle_level;
      end
      else
      begin
         case (state_r.fsm)
            ST_IDLE:
            begin
               state_nxt.sclk = i_clk_idle_level;
               state_nxt.idle = i_clk_idle_level;
               if (take)
               begin
                  state_nxt.cmd = i_cmd_byte;
                  state_nxt.argn = 1'b0;
                  state_nxt.phase = PH_SETUP;
                  state_nxt.hc = 16'h0000;
                  case (i_cmd_byte)
                     OP_DIV5_OFF: state_nxt.div5 = 1'b0;
                     OP_DIV5_ON: state_nxt.div5 = 1'b1;
                     OP_THREE_ON: state_nxt.three = 1'b1;
                     OP_THREE_OFF: state_nxt.three = 1'b0;
                     OP_ADAPT_ON: state_nxt.adapt = 1'b1;
                     OP_ADAPT_OFF: state_nxt.adapt = 1'b0;
                     OP_CLK_UNTIL_HI, OP_CLK_UNTIL_LO: state_nxt.fsm = ST_RUN;
                     OP_SET_DIVISOR, OP_CLK_BITS, OP_CLK_BYTES, OP_BYTES_OR_HI,
                     OP_BYTES_OR_LO, OP_DRIVE_ZERO: state_nxt.fsm = ST_ARG;
                     default: state_nxt.fsm = ST_IDLE;
                  endcase
               end
            end
            ST_ARG:
            begin
               if (take && !state_r.argn)
               begin
                  state_nxt.low_byte = i_cmd_byte;
                  state_nxt.argn = 1'b1;
                  if (state_r.cmd == OP_CLK_BITS)
                  begin
                     state_nxt.pulses = {17'h00000, i_cmd_byte[2:0]} + 20'h00001;
                     state_nxt.fsm = ST_RUN;
                  end
               end
               else if (take)
               begin
                  case (state_r.cmd)
                     OP_SET_DIVISOR:
                     begin
                        state_nxt.divisor = len;
                        state_nxt.fsm = ST_IDLE;
                     end
                     OP_DRIVE_ZERO:
                     begin
                        state_nxt.mask = len;
                        state_nxt.fsm = ST_IDLE;
                     end
                     default:
                     begin
                        state_nxt.pulses = {len_p1, 3'b000};
                        state_nxt.fsm = ST_RUN;
                     end
                  endcase
               end
            end
            ST_RUN:
            begin
               // no new byte is taken until the pulse count, the wait line or a dropped control enable ends the run
               if (adv && state_r.hc != state_r.divisor)
               begin
                  state_nxt.hc = state_r.hc + 16'h0001;
               end
               else if (adv)
               begin
                  state_nxt.hc = 16'h0000;
                  case (state_r.phase)
                     PH_SETUP:
                     begin
                        state_nxt.phase = PH_PULSE;
                        state_nxt.sclk = !state_r.idle;
                     end
                     PH_PULSE:
                     begin
                        state_nxt.sclk = state_r.idle;
                        state_nxt.phase = state_r.three ? PH_HOLD : PH_SETUP;
                     end
                     default:
                        state_nxt.phase = PH_SETUP;
                  endcase
                  if ((state_r.phase == PH_PULSE && !state_r.three) ||
                      state_r.phase == PH_HOLD)
                  begin
                     counted = state_r.cmd != OP_CLK_UNTIL_HI &&
                        state_r.cmd != OP_CLK_UNTIL_LO;
                     wait_hit = ((state_r.cmd == OP_CLK_UNTIL_HI ||
                                  state_r.cmd == OP_BYTES_OR_HI) && state_r.wait_s2) ||
                                ((state_r.cmd == OP_CLK_UNTIL_LO ||
                                  state_r.cmd == OP_BYTES_OR_LO) && !state_r.wait_s2);
                     if (wait_hit || (counted && state_r.pulses == 20'h00001))
                     begin
                        state_nxt.fsm = ST_IDLE;
                     end
                     else if (counted)
                     begin
                        state_nxt.pulses = state_r.pulses - 20'h00001;
                     end
                  end
               end
            end
            default:
               state_nxt.fsm = ST_IDLE;
         endcase
      end
      state_nxt.data_out = state_r.data_out;
      state_nxt.ready = state_nxt.fsm != ST_RUN;
      state_nxt.busy = state_nxt.fsm == ST_RUN;
   end

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_r <= STATE_RST;
      end
      else if (i_clk_en)
      begin
         state_r <= state_nxt;
      end
   end

   assign o_cmd_ready = state_r.ready;
   assign o_sclk = state_r.sclk;
   assign o_data_out = state_r.data_out;
   assign o_pin_drive = state_r.pins;
   assign o_status = '{busy: state_r.busy, div5: state_r.div5,
      three_phase: state_r.three, adaptive: state_r.adapt,
      divisor: state_r.divisor, drive_zero_mask: state_r.mask};
endmodule

// ==== serial_clock_monitor.sv ====
// assertion checker for the clock command block
`timescale 1ns/10ps
module serial_clock_monitor
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_clk_en,
   input wire logic i_ctrl_enable,
   input wire logic i_cmd_valid,
   input wire logic [7:0] i_cmd_byte,
   input wire logic o_cmd_ready,
   input wire logic i_clk_idle_level,
   input wire serial_clock_pkg::pin_cfg_t i_pin_cfg,
   input wire logic o_sclk,
   input wire logic o_data_out,
   input wire serial_clock_pkg::pin_drive_t o_pin_drive,
   input wire serial_clock_pkg::status_t o_status
);
   import serial_clock_pkg::*;
   logic [1:0] args_r;
   logic take;
   logic op;
   assign take = i_clk_en & i_ctrl_enable & i_cmd_valid & o_cmd_ready;
   // op marks an opcode byte, not an argument byte
   assign op = take & (args_r == 2'h0);
   always_ff @(posedge i_clock or posedge i_rst)
      if (i_rst)
         args_r <= 2'h0;
      else if (i_clk_en && !i_ctrl_enable)
         args_r <= 2'h0;
      else if (take && args_r != 2'h0)
         args_r <= args_r - 2'h1;
      else if (op && i_cmd_byte == OP_CLK_BITS)
         args_r <= 2'h1;
      else if (op && i_cmd_byte inside {OP_SET_DIVISOR, OP_CLK_BYTES, OP_BYTES_OR_HI,
         OP_BYTES_OR_LO, OP_DRIVE_ZERO})
         args_r <= 2'h2;
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   a_div5_off: assert property (op && i_cmd_byte == OP_DIV5_OFF |=> !o_status.div5)
      else $error("divide stage still on");
   a_div5_on: assert property (op && i_cmd_byte == OP_DIV5_ON |=> o_status.div5)
      else $error("divide stage still off");
   a_three_on: assert property (op && i_cmd_byte == OP_THREE_ON |=> o_status.three_phase)
      else $error("three phase not set");
   a_three_off: assert property (op && i_cmd_byte == OP_THREE_OFF |=> !o_status.three_phase)
      else $error("three phase still set");
   a_adapt_on: assert property (op && i_cmd_byte == OP_ADAPT_ON |=> o_status.adaptive)
      else $error("adaptive not set");
   a_adapt_off: assert property (op && i_cmd_byte == OP_ADAPT_OFF |=> !o_status.adaptive)
      else $error("adaptive still set");
   a_clock_rest: assert property (o_cmd_ready && $past(o_cmd_ready) && !$past(i_rst)
      && $past(i_clk_en) |-> o_sclk == $past(i_clk_idle_level))
      else $error("clock not at rest level");
   a_fast_pulse: assert property ($rose(o_sclk) && !o_status.div5 && !o_status.adaptive
      && o_status.divisor == 16'h0 && i_clk_en && !o_cmd_ready && !i_clk_idle_level
      |=> !o_sclk) else $error("pulse too long");
   a_pin_drive: assert property (!$past(i_rst) && $stable(o_status.drive_zero_mask)
      && $past(i_clk_en)
      |-> o_pin_drive.oe_n == $past(~i_pin_cfg.dir | (o_status.drive_zero_mask
      & i_pin_cfg.data))) else $error("pin enable wrong");
   a_data_still: assert property (o_data_out == 1'b0)
      else $error("data output moved");
endmodule
bind serial_engine_clock_commands serial_clock_monitor mon (.*);

// ==== serial_target.sv ====
// target model returning the test clock after a selectable lag
`timescale 1ns/10ps
module serial_target
(
   input wire logic i_clock,
   input wire logic i_sclk,
   input wire logic [2:0] i_lag,
   output logic o_return_clk
);
   logic [7:0] pipe_r = 8'h00;
   always_ff @(posedge i_clock)
      pipe_r <= {pipe_r[6:0], i_sclk};
   assign o_return_clk = pipe_r[i_lag];
endmodule

// ==== serial_engine_clock_commands_tb.sv ====
// self-checking bench for the clock command block
`timescale 1ns/10ps
module serial_engine_clock_commands_tb;
   import serial_clock_pkg::*;
   logic clk, rst, en, ce, valid, wait_ln, idle, ready, sclk, dout, ret_clk;
   logic [7:0] cmd;
   logic [2:0] lag;
   logic [15:0] dv;
   logic [23:0] cb;
   pin_cfg_t cfg;
   pin_drive_t drv;
   status_t st;
   int error_cnt, comparisons, n, w, c, c2;
   logic [7:0] ops [6] = '{OP_DIV5_OFF, OP_DIV5_ON, OP_THREE_ON, OP_THREE_OFF, OP_ADAPT_ON,
      OP_ADAPT_OFF};
   logic [2:0] modes [6] = '{3'h0, 3'h4, 3'h6, 3'h4, 3'h5, 3'h4};
   serial_engine_clock_commands DUT (.i_clock(clk), .i_rst(rst), .i_clk_en(ce),
      .i_ctrl_enable(en), .i_cmd_valid(valid), .i_cmd_byte(cmd), .o_cmd_ready(ready),
      .i_wait_input_line(wait_ln), .i_return_clock_input(ret_clk), .i_clk_idle_level(idle),
      .i_pin_cfg(cfg), .o_sclk(sclk), .o_data_out(dout), .o_pin_drive(drv), .o_status(st));
   serial_target target (.i_clock(clk), .i_sclk(sclk), .i_lag(lag), .o_return_clk(ret_clk));
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task check(input logic [35:0] seen, input logic [35:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task conclude;
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   function int pulses(input logic [23:0] b);
      return (b[7:0] == OP_CLK_BITS) ? b[10:8] + 1 : 8 * (b[23:8] + 1);
   endfunction
   // k bytes, opcode in the low byte
   task push(input int k, input logic [23:0] b);
      valid <= 1'b1;
      for (int i = 0; i < k; i++)
      begin
         cmd <= b[8*i +: 8];
         do @(posedge clk); while (!ready);
      end
      valid <= 1'b0;
      @(posedge clk);
   endtask
   // n pulses, w high width of last pulse, c busy span
   task run(input int k, input logic [23:0] b);
      logic busy;
      logic prev;
      busy = 1'b0;
      prev = sclk;
      {n, w, c} = 0;
      cb = b;
      push(k, b);
      while (c < 2000 && !(busy && ready))
      begin
         @(posedge clk);
         c++;
         busy |= !ready;
         n += (sclk && !prev);
         w = sclk ? (prev ? w + 1 : 1) : w;
         prev = sclk;
      end
      check(busy && ready, 1'b1);
   endtask
   task hold(input logic [7:0] op, input logic lvl, input logic rel);
      wait_ln <= !lvl;
      push(1, {16'h0, op});
      repeat (40) @(posedge clk);
      check(ready, 1'b0);
      if (rel)
         wait_ln <= lvl;
      else
         en <= 1'b0;
      for (int t = 0; t < 20 && !ready; t++) @(posedge clk);
      en <= 1'b1;
      check(ready, 1'b1);
   endtask
   initial
   begin
      void'($urandom(32'h7d52));
      {rst, en, ce, valid, wait_ln, idle, cmd, lag, cfg} = {6'h38, 8'h0, 3'h1, 32'h0};
      repeat (3) @(posedge clk);
      check(drv, 32'hffffffff);
      rst <= 1'b0;
      @(posedge clk);
      check(st, {1'b0, RST_DIV5, RST_THREE_PHASE, RST_ADAPTIVE, 32'h0});
      foreach (ops[i])
      begin
         push(1, {16'h0, ops[i]});
         check(st[34:32], modes[i]);
      end
      $display("test modes done");
      dv = 16'($urandom);
      push(3, {dv, OP_SET_DIVISOR});
      check(st.divisor, dv);
      push(1, {16'h0, OP_DIV5_OFF});
      for (int i = 0; i < 4; i++)
      begin
         dv = 16'($urandom_range(3, 0));
         push(3, {dv, OP_SET_DIVISOR});
         run(2, {13'h0, (i == 0) ? 3'h7 : 3'($urandom), OP_CLK_BITS});
         check(n, pulses(cb));
         check(w, dv + 1);
      end
      push(1, {16'h0, OP_DIV5_ON});
      run(2, {16'h0, OP_CLK_BITS});
      check(w, 5 * (dv + 1));
      push(3, {16'h0, OP_SET_DIVISOR});
      push(1, {16'h0, OP_DIV5_OFF});
      run(3, {16'h0002, OP_CLK_BYTES});
      check(n, pulses(cb));
      run(2, {16'h0002, OP_CLK_BITS});
      c2 = c;
      push(1, {16'h0, OP_THREE_ON});
      run(2, {16'h0002, OP_CLK_BITS});
      check(c - c2, 3);
      push(1, {16'h0, OP_THREE_OFF});
      run(2, {16'h0002, OP_CLK_BITS});
      check(c, c2);
      lag <= 3'h3;
      push(1, {16'h0, OP_ADAPT_ON});
      run(2, {16'h0003, OP_CLK_BITS});
      check(n, 4);
      check(w > 3, 1'b1);
      push(1, {16'h0, OP_ADAPT_OFF});
      run(2, {16'h0003, OP_CLK_BITS});
      check(w, 1);
      $display("test counts done");
      hold(OP_CLK_UNTIL_HI, 1'b1, 1'b1);
      hold(OP_CLK_UNTIL_LO, 1'b0, 1'b1);
      hold(OP_CLK_UNTIL_LO, 1'b0, 1'b0);
      run(3, {16'h0005, OP_BYTES_OR_HI});
      check(n, 1);
      wait_ln <= 1'b0;
      run(3, {16'h0005, OP_BYTES_OR_HI});
      check(n, pulses(cb));
      run(3, {16'h0005, OP_BYTES_OR_LO});
      check(n, 1);
      $display("test waits done");
      idle <= 1'b1;
      repeat (3) @(posedge clk);
      check(sclk, 1'b1);
      idle <= 1'b0;
      dv = 16'($urandom);
      push(3, {dv, OP_DRIVE_ZERO});
      check(st.drive_zero_mask, dv);
      cfg <= pin_cfg_t'($urandom);
      repeat (2) @(posedge clk);
      check(drv.oe_n, 16'(~cfg.dir | (dv & cfg.data)));
      check(dout, 1'b0);
      $display("test pins done");
      // a low clock enable must freeze a running command in place
      push(2, {16'h0007, OP_CLK_BITS});
      ce <= 1'b0;
      @(posedge clk);
      c2 = sclk;
      repeat (30) @(posedge clk);
      check({ready, sclk}, {1'b0, c2[0]});
      ce <= 1'b1;
      repeat (30) @(posedge clk);
      check(ready, 1'b1);
      $display("test freeze done");
      conclude();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      conclude();
   end
endmodule
